/* bwfh_regs.svh */
/*
  timing and layout constants for the byte-wide buffer port.
  assumes inclusion by both ends; definitions only.
*/
`ifndef BWFH_REGS_SVH
`define BWFH_REGS_SVH
`define BWFH_DATA_W     8
`define BWFH_DEPTH      16
`define BWFH_PTR_W      4
`define BWFH_CNT_W      5
`define BWFH_STROBE_NS  120
`define BWFH_CLK_NS     40
`define BWFH_STROBE_CYC (((`BWFH_STROBE_NS) + (`BWFH_CLK_NS) - 1) / (`BWFH_CLK_NS))
`define BWFH_TMR_W      4
`define BWFH_TMR_ZERO   4'h0
`define BWFH_BYTE_ZERO  8'h00
`define BWFH_PAD_COUNT  12
`endif

/* bwfh_pkg.sv */
/*
  types used by the host end of the byte-wide buffer port.
  assumes bwfh_regs.svh is compiled alongside.
*/
package bwfh_pkg;
  typedef logic [7:0] bwfh_byte_t;
  typedef enum logic [2:0] {
    BWFH_IDLE,
    BWFH_WR_SETUP,
    BWFH_WR_LOW,
    BWFH_RD_LOW,
    BWFH_RD_HIGH
  } bwfh_host_state_t;
endpackage : bwfh_pkg

/* bwfh_if.sv */
/*
  pins between the device end and the host end of the byte port.
  assumes the testbench resolves the shared data lines from the enables.
*/
`timescale 1ns/1ps
interface bwfh_if;
  logic       txe_n;
  logic       rxf_n;
  logic       wr_n;
  logic       rd_n;
  logic       oe_n;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic [7:0] data_lines;
  modport device (
    output txe_n, rxf_n, dev_data_out, dev_data_oe,
    input  wr_n, rd_n, oe_n, data_lines
  );
  modport host (
    input  txe_n, rxf_n, data_lines,
    output wr_n, rd_n, oe_n, host_data_out, host_data_oe
  );
endinterface : bwfh_if

/* bwfh_device.sv */
/*
  device end of the byte-wide buffer port: transmit buffer filled by the
  host, receive buffer drained by the host, asynchronous strobe variant.
  assumes host strobes are asynchronous to clock; user side is same-clock.
*/
`timescale 1ns/1ps
`include "bwfh_regs.svh"
module bwfh_device (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // host pins
  bwfh_if.device                         port,
  // transmit side toward user logic
  output      logic [7:0]                tx_data,
  output      logic                      tx_valid,
  input  wire logic                      tx_ready,
  // receive side from user logic
  input  wire logic [7:0]                rx_data,
  input  wire logic                      rx_valid,
  output      logic                      rx_ready,
  // pad routing state
  output      logic [`BWFH_PAD_COUNT-1:0] mux_pad_default
);
  // three-stage synchronisers for the asynchronous strobes
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic [7:0] data_s1;
  logic [7:0] data_s2;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_sync <= 3'h7;
      rd_sync <= 3'h7;
      data_s1 <= `BWFH_BYTE_ZERO;
      data_s2 <= `BWFH_BYTE_ZERO;
    end else begin
      wr_sync <= {wr_sync[1:0], port.wr_n};
      rd_sync <= {rd_sync[1:0], port.rd_n};
      data_s1 <= port.data_lines;
      data_s2 <= data_s1;
    end
  end
  // a change counts once stages two and three agree
  logic wr_state;
  logic rd_state;
  wire  wr_agree = (wr_sync[1] == wr_sync[2]);
  wire  rd_agree = (rd_sync[1] == rd_sync[2]);
  wire  wr_fall  = wr_agree && wr_state && !wr_sync[2];
  wire  rd_fall  = rd_agree && rd_state && !rd_sync[2];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_state <= 1'b1;
      rd_state <= 1'b1;
    end else begin
      if (wr_agree) wr_state <= wr_sync[2];
      if (rd_agree) rd_state <= rd_sync[2];
    end
  end

  // transmit buffer
  logic [7:0]             tx_mem [`BWFH_DEPTH];
  logic [`BWFH_PTR_W-1:0] tx_wp;
  logic [`BWFH_PTR_W-1:0] tx_rp;
  logic [`BWFH_CNT_W-1:0] tx_cnt;
  wire  tx_full   = (tx_cnt == `BWFH_CNT_W'(`BWFH_DEPTH));
  wire  tx_push   = wr_fall && !tx_full;
  wire  tx_pop    = tx_valid && tx_ready;
  wire  tx_nempty = (tx_cnt != '0);
  wire  [`BWFH_CNT_W-1:0] next_tx_cnt =
    tx_cnt + `BWFH_CNT_W'(tx_push) - `BWFH_CNT_W'(tx_pop);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 1'b1;
      if (tx_pop) tx_rp <= tx_rp + 1'b1;
      tx_cnt <= next_tx_cnt;
    end
  end
  // data settled two cycles before the strobe edge is seen
  always_ff @(posedge clock) begin
    if (tx_push) tx_mem[tx_wp] <= data_s2;
  end
  // user output registered; refilled only after it is taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data  <= `BWFH_BYTE_ZERO;
    end else if (!tx_valid && tx_nempty) begin
      tx_valid <= 1'b1;
      tx_data  <= tx_mem[tx_rp];
    end else if (tx_pop) begin
      tx_valid <= (tx_cnt > `BWFH_CNT_W'(1));
      tx_data  <= tx_mem[tx_rp + 1'b1];
    end
  end
  // tx_pop counts the registered word; tx_cnt tracks words not yet taken

  // flag raised the cycle after the filling write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) port.txe_n <= 1'b1;
    else     port.txe_n <= (next_tx_cnt == `BWFH_CNT_W'(`BWFH_DEPTH));
  end

  // receive buffer
  logic [7:0]             rx_mem [`BWFH_DEPTH];
  logic [`BWFH_PTR_W-1:0] rx_wp;
  logic [`BWFH_PTR_W-1:0] rx_rp;
  logic [`BWFH_CNT_W-1:0] rx_cnt;
  wire  rx_full  = (rx_cnt == `BWFH_CNT_W'(`BWFH_DEPTH));
  // only a byte offered while ready is shown counts as taken
  wire  rx_push  = rx_valid && rx_ready && !rx_full;
  wire  rx_pop   = rd_fall && (rx_cnt != '0);
  wire  [`BWFH_CNT_W-1:0] next_rx_cnt =
    rx_cnt + `BWFH_CNT_W'(rx_push) - `BWFH_CNT_W'(rx_pop);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
      rx_ready <= 1'b0;
    end else begin
      if (rx_push) rx_wp <= rx_wp + 1'b1;
      if (rx_pop) rx_rp <= rx_rp + 1'b1;
      rx_cnt <= next_rx_cnt;
      rx_ready <= (next_rx_cnt < `BWFH_CNT_W'(`BWFH_DEPTH));
    end
  end
  always_ff @(posedge clock) begin
    if (rx_push) rx_mem[rx_wp] <= rx_data;
  end
  // current byte: head fetched on each read falling edge while the buffer holds a byte, held until the next
  wire [7:0] head_byte = rx_mem[rx_rp];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port.rxf_n        <= 1'b1;
      port.dev_data_out <= `BWFH_BYTE_ZERO;
      port.dev_data_oe  <= 1'b0;
    end else begin
      port.rxf_n        <= (next_rx_cnt == '0);
      if (rx_pop) port.dev_data_out <= head_byte;
      // drive only while the filtered strobe is low
      port.dev_data_oe  <= (rd_agree ? !rd_sync[2] : !rd_state);
    end
  end

  // asynchronous variant: output enable and port clock unused
  wire unused_oe = port.oe_n;

  // pads stay in default routing after a hard reset; no reconfiguration path
  always_ff @(posedge clock or posedge rst) begin
    if (rst) mux_pad_default <= '1;
    else     mux_pad_default <= '1;
  end
endmodule : bwfh_device

/* bwfh_host.sv */
/*
  host end of the byte-wide buffer port: writes bytes when space is shown,
  reads bytes when data is shown, strobes held a fixed number of cycles.
  assumes device flags are asynchronous; user side is same-clock.
*/
`timescale 1ns/1ps
`include "bwfh_regs.svh"
module bwfh_host (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // device pins
  bwfh_if.host            port,
  // bytes to send
  input  wire logic [7:0] wr_byte,
  input  wire logic       wr_valid,
  output      logic       wr_ready,
  // bytes received
  output      logic [7:0] rd_byte,
  output      logic       rd_valid
);
  logic [2:0] txe_sync;
  logic [2:0] rxf_sync;
  logic [7:0] din_s1;
  logic [7:0] din_s2;
  logic       txe_n_f;
  logic       rxf_n_f;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txe_sync <= 3'h7;
      rxf_sync <= 3'h7;
      din_s1 <= `BWFH_BYTE_ZERO;
      din_s2 <= `BWFH_BYTE_ZERO;
      txe_n_f <= 1'b1;
      rxf_n_f <= 1'b1;
    end else begin
      txe_sync <= {txe_sync[1:0], port.txe_n};
      rxf_sync <= {rxf_sync[1:0], port.rxf_n};
      din_s1 <= port.data_lines;
      din_s2 <= din_s1;
      if (txe_sync[1] == txe_sync[2]) txe_n_f <= txe_sync[2];
      if (rxf_sync[1] == rxf_sync[2]) rxf_n_f <= rxf_sync[2];
    end
  end

  bwfh_pkg::bwfh_host_state_t state;
  bwfh_pkg::bwfh_host_state_t next_state;
  logic [`BWFH_TMR_W-1:0] tmr;
  wire  tmr_done  = (tmr == `BWFH_TMR_ZERO);
  wire  can_write = wr_valid && !txe_n_f;
  wire  can_read  = !rxf_n_f;
  always_comb begin
    next_state = state;
    unique case (state)
      bwfh_pkg::BWFH_IDLE:
        if (can_read) next_state = bwfh_pkg::BWFH_RD_LOW;
        else if (can_write) next_state = bwfh_pkg::BWFH_WR_SETUP;
      bwfh_pkg::BWFH_WR_SETUP: if (tmr_done) next_state = bwfh_pkg::BWFH_WR_LOW;
      bwfh_pkg::BWFH_WR_LOW:   if (tmr_done) next_state = bwfh_pkg::BWFH_RD_HIGH;
      bwfh_pkg::BWFH_RD_LOW:   if (tmr_done) next_state = bwfh_pkg::BWFH_RD_HIGH;
      // recovery covers the device's flag delay through its synchroniser
      bwfh_pkg::BWFH_RD_HIGH:  if (tmr_done) next_state = bwfh_pkg::BWFH_IDLE;
    endcase
  end
  wire entering = (next_state != state);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= bwfh_pkg::BWFH_IDLE;
      tmr <= `BWFH_TMR_ZERO;
      port.wr_n <= 1'b1;
      port.rd_n <= 1'b1;
      port.oe_n <= 1'b1;
      port.host_data_out <= `BWFH_BYTE_ZERO;
      port.host_data_oe <= 1'b0;
      wr_ready <= 1'b0;
      rd_byte <= `BWFH_BYTE_ZERO;
      rd_valid <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= entering ? `BWFH_TMR_W'(`BWFH_STROBE_CYC * 2) : tmr - 1'b1;
      if (tmr_done && !entering) tmr <= `BWFH_TMR_ZERO;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
      if (state == bwfh_pkg::BWFH_IDLE && next_state == bwfh_pkg::BWFH_WR_SETUP) begin
        port.host_data_out <= wr_byte;
        port.host_data_oe <= 1'b1;
        wr_ready <= 1'b1;
      end
      port.wr_n <= !(next_state == bwfh_pkg::BWFH_WR_SETUP);
      port.rd_n <= !(next_state == bwfh_pkg::BWFH_RD_LOW);
      if (state == bwfh_pkg::BWFH_RD_LOW && entering) begin
        rd_byte <= din_s2;
        rd_valid <= 1'b1;
      end
      if (state == bwfh_pkg::BWFH_RD_HIGH && entering)
        port.host_data_oe <= 1'b0;
    end
  end
endmodule : bwfh_host

/* bwfh_assertions.sv */
/*
  concurrent checks on the pins joining the device end and the host end.
  assumes instantiation beside the interface, signals passed by name.
*/
`timescale 1ns/1ps
module bwfh_assertions (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // flags and strobes
  input wire logic       txe_n,
  input wire logic       rxf_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic       oe_n,
  // data lines
  input wire logic [7:0] dev_data_out,
  input wire logic       dev_data_oe,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe,
  input wire logic [7:0] data_lines
);
  default clocking dflt @(posedge clock); endclocking
  default disable iff (rst);

  reset_quiet_a: assert property (disable iff (1'b0)
    rst |-> txe_n && rxf_n && wr_n && rd_n && !dev_data_oe && !host_data_oe)
    else $error("pins not quiet during reset");
  write_gate_a: assert property ($fell(wr_n) |-> !$past(txe_n))
    else $error("write strobe while space flag high");
  read_gate_a: assert property ($fell(rd_n) |-> !$past(rxf_n))
    else $error("read strobe while available flag high");
  drive_read_a: assert property ($fell(rd_n) |-> ##[1:5] dev_data_oe)
    else $error("device did not drive during read");
  release_bus_a: assert property (rd_n [*6] |-> !dev_data_oe)
    else $error("device drives with read strobe high");
  one_driver_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data lines");
  wr_pulse_a: assert property ($fell(wr_n) |-> !wr_n [*7] ##1 wr_n)
    else $error("write strobe width wrong");
  rd_pulse_a: assert property ($fell(rd_n) |-> !rd_n [*7] ##1 rd_n [*8])
    else $error("read strobe width or recovery wrong");
  wr_data_a: assert property (!wr_n && !$fell(wr_n) |->
    host_data_oe && $stable(host_data_out))
    else $error("write data moved while strobe low");
  oe_idle_a: assert property (oe_n)
    else $error("output enable strobe used");
endmodule : bwfh_assertions

/* test_byte_wide_fifo_host_port.sv */
/*
  bench joining both ends; user sides driven randomly, outputs compared
  with queues. assumes design files and bwfh_regs.svh compiled first.
*/
`timescale 1ns/1ps
`include "bwfh_regs.svh"
module test_byte_wide_fifo_host_port;
  logic        clock = 1'b0, rst = 1'b0, drain = 1'b0;
  logic        wr_valid = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0;
  logic        wr_ready, rd_valid, tx_valid, rx_ready;
  logic [7:0]  wr_byte = 8'h00, rx_data = 8'h00, pat = 8'h00;
  logic [7:0]  rd_byte, tx_data;
  logic [11:0] pads;
  logic [7:0]  txq[$], rxq[$];
  int          bad_count = 0, compares = 0, cycles = 0;

  bwfh_if i_bwfh_if ();
  always #20 clock = ~clock;
  // released lines churn so a stale byte never reads back right
  always @(posedge clock) pat <= pat + 8'h35;
  assign i_bwfh_if.data_lines = i_bwfh_if.dev_data_oe ? i_bwfh_if.dev_data_out :
                                i_bwfh_if.host_data_oe ? i_bwfh_if.host_data_out : pat;

  bwfh_device i_bwfh_device (.clock(clock), .rst(rst), .port(i_bwfh_if.device),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .mux_pad_default(pads));
  bwfh_host i_bwfh_host (.clock(clock), .rst(rst), .port(i_bwfh_if.host),
    .wr_byte(wr_byte), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_byte(rd_byte), .rd_valid(rd_valid));
  bwfh_assertions chk (.clock(clock), .rst(rst), .txe_n(i_bwfh_if.txe_n),
    .rxf_n(i_bwfh_if.rxf_n), .wr_n(i_bwfh_if.wr_n), .rd_n(i_bwfh_if.rd_n),
    .oe_n(i_bwfh_if.oe_n), .dev_data_out(i_bwfh_if.dev_data_out),
    .dev_data_oe(i_bwfh_if.dev_data_oe), .host_data_out(i_bwfh_if.host_data_out),
    .host_data_oe(i_bwfh_if.host_data_oe), .data_lines(i_bwfh_if.data_lines));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic send(input int n);
    repeat (n) begin
      wr_byte = 8'($urandom);
      wr_valid = 1'b1;
      do @(posedge clock); while (wr_ready !== 1'b1);
      txq.push_back(wr_byte);
      #1;
    end
    // a held offer would be taken again without being queued
    wr_valid = 1'b0;
  endtask : send

  task automatic feed(input int n);
    repeat (n) begin
      rx_data = 8'($urandom);
      rx_valid = 1'b1;
      do @(posedge clock); while (rx_ready !== 1'b1);
      rxq.push_back(rx_data);
      #1;
    end
    rx_valid = 1'b0;
  endtask : feed

  always @(posedge clock) #1 tx_ready = drain && ($urandom % 3 != 0);

  always @(posedge clock) begin
    cycles++;
    if ((tx_valid & tx_ready) === 1'b1)
      check(12'(tx_data), 12'(txq.size() ? txq.pop_front() : 8'hXX));
    if (rd_valid === 1'b1)
      check(12'(rd_byte), 12'(rxq.size() ? rxq.pop_front() : 8'hXX));
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'h82f6b612));
    #5 rst = 1'b1;
    repeat (16) @(posedge clock);
    check(12'({i_bwfh_if.txe_n, i_bwfh_if.rxf_n}), 12'h003);
    #1 rst = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(pads, {`BWFH_PAD_COUNT{1'b1}});
    check(12'(i_bwfh_if.txe_n), 12'h000);
    // sink stalled, so the transmit buffer fills while bytes also flow back
    fork
      send(`BWFH_DEPTH);
      feed(12);
    join
    repeat (12) @(posedge clock);
    check(12'(i_bwfh_if.txe_n), 12'h001);
    // offer a byte while full; it must be refused, and is replaced below
    #1 wr_valid = 1'b1;
    repeat (40) begin
      @(posedge clock);
      check(12'(wr_ready), 12'h000);
    end
    #1 drain = 1'b1;
    fork
      send(10);
      feed(20);
    join
    wr_valid = 1'b0;
    for (int i = 0; i < 3000 && txq.size() + rxq.size() > 0; i++) @(posedge clock);
    repeat (8) @(posedge clock);
    check(12'(txq.size() + rxq.size()), 12'h000);
    check(12'({i_bwfh_if.txe_n, i_bwfh_if.rxf_n}), 12'h001);
    stop_test();
  end
endmodule : test_byte_wide_fifo_host_port
